// file: core/srbt_core.sv
// Read burst engine of a DDR memory device with an APB register file
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// How it works
// - Reads run as fixed eight beats, fixed four-beat chop, or chosen per command.
// - In per-command mode, address bit 12 low chops to four, high gives eight.
// - Address bit 10 low is a plain read; the bank stays open.
// - Address bit 10 high precharges the bank once its burst finishes.
// - Burst field 00 means fixed eight beats, 01 means per-command selection.
// - Burst field 10 chops every read to four beats.
// - First beat appears additive plus cas latency clocks after the command.
// - Data lines release at latency plus four clocks, or plus two when chopped.
// - Reads are accepted only while the delay-locked loop is enabled and locked.
// - One beat per strobe edge, rising and falling, aligned with the strobe.
// - Strobe preamble before the first beat, postamble after the last, then release.
module srbt_core (
	input  wire logic        clk,
	input  wire logic        clkEn,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        linkClk,
	input  wire logic        cmdRead,
	input  wire logic        cmdActivate,
	input  wire logic [13:0] cmdAddr,
	input  wire logic [3:0]  cmdBank,
	input  wire logic        dllLockPin,
	output logic      [7:0]  dqRise,
	output logic      [7:0]  dqFall,
	output logic             dqOe,
	output logic             dqsT,
	output logic             dqsC,
	output logic             dqsOe
);
	import srbt_pkg::*;

	// --------------------------------------------------------------
	// State of both domains
	// --------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  burst;
		logic [4:0]  cas;
		logic [4:0]  al;
		logic        dllEn;
		logic [2:0]  err;
		logic [2:0]  errSeen;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} srbt_sys_type;

	typedef struct packed {
		logic [6:0]                now;
		srbt_entry_type [3:0]      q;
		logic [1:0]                wp;
		logic [1:0]                rp;
		logic [2:0]                cnt;
		srbt_state_type            st;
		srbt_entry_type            cur;
		logic [1:0]                pair;
		logic [BANKS-1:0]          open;
		logic [2:0]                errTog;
		logic [7:0]                dqRise;
		logic [7:0]                dqFall;
		logic                      dqOe;
		logic                      dqsT;
		logic                      dqsC;
		logic                      dqsOe;
	} srbt_link_type;

	srbt_sys_type  r;
	srbt_sys_type  next_r;
	srbt_link_type l;
	srbt_link_type next_l;

	logic         lRst;
	logic         lEn;
	logic         lLock;
	logic         lockSys;
	logic [2:0]   errSync;
	srbt_cfg_type cfg;

	srbt_word_if #(.WIDTH(CFG_W)) cfgIf();
	srbt_word_if #(.WIDTH(BANKS)) statIf();

	// --------------------------------------------------------------
	// Crossings
	// --------------------------------------------------------------
	// Reset and enable reach the link domain two link clocks late, so a
	// command sent right after release may still be lost to the link reset
	srbt_sync #(.WIDTH(3)) linkSync (
		.clk (linkClk),
		.d   ({sys_rst, clkEn, dllLockPin}),
		.q   ({lRst, lEn, lLock})
	);
	srbt_sync #(.WIDTH(4)) sysSync (
		.clk (clk),
		.d   ({l.errTog, lLock}),
		.q   ({errSync, lockSys})
	);
	// Mode settings travel as one word so latency and burst never mix
	srbt_handshake #(.WIDTH(CFG_W)) cfgXfer (
		.srcClk (clk),
		.srcRst (sys_rst),
		.srcEn  (clkEn),
		.dstClk (linkClk),
		.dstRst (lRst),
		.dstEn  (lEn),
		.port   (cfgIf.xfer)
	);
	// The open-bank map travels back the same way for the status word
	srbt_handshake #(.WIDTH(BANKS)) statXfer (
		.srcClk (linkClk),
		.srcRst (lRst),
		.srcEn  (lEn),
		.dstClk (clk),
		.dstRst (sys_rst),
		.dstEn  (clkEn),
		.port   (statIf.xfer)
	);

	assign cfgIf.srcWord  = {r.dllEn, r.al, r.cas, r.burst};
	assign statIf.srcWord = l.open;
	assign cfg            = srbt_cfg_type'(cfgIf.dstWord);

	// --------------------------------------------------------------
	// APB register file
	// --------------------------------------------------------------
	logic       access;
	logic [2:0] errSet;

	always_comb begin
		next_r = r;
		access = psel & penable;
		errSet = errSync ^ r.errSeen;
		next_r.errSeen = errSync;
		// Ready answers one cycle into the access phase and never stands twice
		next_r.pready = access & ~r.pready;
		if (access && !r.pready) begin
			next_r.pslverr = 1'b0;
			next_r.prdata = RDATA_RST;
			unique case (paddr)
				ADDR_MODE: begin
					next_r.prdata[BURST_LSB +: 2] = r.burst;
					next_r.prdata[CAS_LSB +: 5] = r.cas;
					next_r.prdata[AL_LSB +: 5] = r.al;
					next_r.prdata[DLL_BIT] = r.dllEn;
				end
				ADDR_STATUS: begin
					next_r.prdata[LOCK_BIT] = lockSys;
					next_r.prdata[BUSY_BIT] = cfgIf.srcBusy;
					next_r.prdata[OPEN_LSB +: BANKS] = statIf.dstWord;
				end
				ADDR_ERROR: begin
					next_r.prdata[2:0] = r.err;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end
		// Writes land on the completing edge only
		if (access && r.pready && pwrite && !r.pslverr) begin
			if (paddr == ADDR_MODE) begin
				next_r.burst = pwdata[BURST_LSB +: 2];
				next_r.cas = pwdata[CAS_LSB +: 5];
				next_r.al = pwdata[AL_LSB +: 5];
				next_r.dllEn = pwdata[DLL_BIT];
			end
			if (paddr == ADDR_ERROR) begin
				next_r.err = r.err & ~pwdata[2:0];
			end
		end
		// A new error beats a clear in the same cycle
		next_r.err = next_r.err | errSet;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '{burst: BURST_RST, cas: CAS_RST, al: AL_RST, dllEn: DLL_RST,
			       prdata: RDATA_RST, default: '0};
		end else if (clkEn) begin
			r <= next_r;
		end
	end

	// --------------------------------------------------------------
	// Bus outputs
	// --------------------------------------------------------------
	assign prdata  = r.prdata;
	assign pready  = r.pready;
	assign pslverr = r.pslverr;

	// --------------------------------------------------------------
	// Link side: command intake and burst engine
	// --------------------------------------------------------------
	// Beats count up from the start column and wrap at the byte boundary
	function automatic logic [7:0] beatOf(srbt_entry_type e, logic [1:0] pair, logic odd);
		beatOf = e.col + {5'h00, pair, odd};
	endfunction

	srbt_entry_type head;
	logic [6:0]     rl;
	logic           headDue;
	logic           headNow;
	logic           push;
	logic           pop;
	logic           start;
	logic           chop;
	logic [1:0]     lastPair;

	always_comb begin
		next_l = l;
		push = 1'b0;
		pop = 1'b0;
		start = 1'b0;
		next_l.now = l.now + 7'h01;
		rl = {2'b00, cfg.al} + {2'b00, cfg.cas};
		head = l.q[l.rp];
		// Due marks the first data cycle; the preamble leaves one cycle before,
		// so a read latency below two waits for the seven-bit time count to wrap before it is served
		headDue = (l.cnt != 3'h0) && (head.due == l.now + 7'h01);
		headNow = (l.cnt != 3'h0) && (head.due == l.now);
		// Chop is decided at intake, so a later mode change spares queued reads
		chop = (cfg.burst == BURST_CHOP4)
		     | ((cfg.burst == BURST_OTF) & ~cmdAddr[12]);
		lastPair = l.cur.chop ? LAST_PAIR_CHOP : LAST_PAIR_EIGHT;

		// A refused read only flips its error toggle; nothing is queued.
		// Four reads may wait; a fifth is refused rather than stalling the link
		if (cmdRead) begin
			if (!(cfg.dllEn && lLock)) begin
				next_l.errTog[0] = ~l.errTog[0];
			end else if (!l.open[cmdBank]) begin
				next_l.errTog[1] = ~l.errTog[1];
			end else if (l.cnt == QUEUE_DEPTH) begin
				next_l.errTog[2] = ~l.errTog[2];
			end else begin
				push = 1'b1;
			end
		end

		// Drivers fall back to released unless a state below holds them
		next_l.dqOe = 1'b0;
		next_l.dqsOe = 1'b0;
		next_l.dqsT = 1'b0;
		next_l.dqsC = 1'b0;
		unique case (l.st)
			ST_IDLE, ST_POST: begin
				next_l.st = ST_IDLE;
				if (headDue) begin
					next_l.st = ST_PRE;
					next_l.dqsOe = 1'b1;
					next_l.dqsC = 1'b1;
				end
			end
			ST_PRE: begin
				start = 1'b1;
			end
			ST_DATA: begin
				if (l.pair == lastPair) begin
					if (l.cur.ap) begin
						next_l.open[l.cur.bank] = 1'b0;
					end
					// Back-to-back reads stream on without a gap in the strobe
					if (headNow) begin
						start = 1'b1;
					end else if (headDue) begin
						// One idle cycle: the postamble doubles as the next preamble
						next_l.st = ST_PRE;
						next_l.dqsOe = 1'b1;
						next_l.dqsC = 1'b1;
					end else begin
						next_l.st = ST_POST;
						next_l.dqsOe = 1'b1;
						next_l.dqsC = 1'b1;
					end
				end else begin
					next_l.pair = l.pair + 2'h1;
					next_l.dqRise = beatOf(l.cur, l.pair + 2'h1, 1'b0);
					next_l.dqFall = beatOf(l.cur, l.pair + 2'h1, 1'b1);
					next_l.dqOe = 1'b1;
					next_l.dqsOe = 1'b1;
					next_l.dqsT = 1'b1;
				end
			end
		endcase

		if (start) begin
			pop = 1'b1;
			next_l.st = ST_DATA;
			next_l.cur = head;
			next_l.pair = 2'h0;
			next_l.dqRise = beatOf(head, 2'h0, 1'b0);
			next_l.dqFall = beatOf(head, 2'h0, 1'b1);
			next_l.dqOe = 1'b1;
			next_l.dqsOe = 1'b1;
			next_l.dqsT = 1'b1;
		end

		if (push) begin
			next_l.q[l.wp] = '{bank: cmdBank, col: cmdAddr[7:0], chop: chop,
			                   ap: cmdAddr[10], due: l.now + rl};
			next_l.wp = l.wp + 2'h1;
		end
		if (pop) begin
			next_l.rp = l.rp + 2'h1;
		end
		next_l.cnt = l.cnt + {2'b00, push} - {2'b00, pop};

		// Activate after precharge so a same-cycle open wins
		if (cmdActivate) begin
			next_l.open[cmdBank] = 1'b1;
		end
	end

	// The link state freezes with the synced enable, two link clocks after the system side stops
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			l <= '0;
		end else if (lEn) begin
			l <= next_l;
		end
	end

	// --------------------------------------------------------------
	// Link outputs
	// --------------------------------------------------------------
	assign dqRise = l.dqRise;
	assign dqFall = l.dqFall;
	assign dqOe   = l.dqOe;
	assign dqsT   = l.dqsT;
	assign dqsC   = l.dqsC;
	assign dqsOe  = l.dqsOe;
endmodule : srbt_core

// file: core/srbt_handshake.sv
// Toggle handshake that carries a whole word across clock domains
`timescale 1ns/1ps
module srbt_handshake #(parameter int WIDTH = 16) (
	input  wire logic  srcClk,
	input  wire logic  srcRst,
	input  wire logic  srcEn,
	input  wire logic  dstClk,
	input  wire logic  dstRst,
	input  wire logic  dstEn,
	srbt_word_if.xfer  port
);
	typedef struct packed {
		logic             req;
		logic             busy;
		logic [WIDTH-1:0] hold;
		logic             ack1;
		logic             ack2;
	} srbt_src_type;
	typedef struct packed {
		logic             req1;
		logic             req2;
		logic             ack;
		logic [WIDTH-1:0] word;
		logic             fresh;
	} srbt_dst_type;
	srbt_src_type s;
	srbt_src_type next_s;
	srbt_dst_type d;
	srbt_dst_type next_d;

	// Hold stays frozen while a request is in flight, so the far side may copy it
	always_comb begin
		next_s = s;
		next_s.ack1 = d.ack;
		next_s.ack2 = s.ack1;
		if (!s.busy) begin
			next_s.hold = port.srcWord;
			next_s.req = ~s.req;
			next_s.busy = 1'b1;
		end else if (s.ack2 == s.req) begin
			next_s.busy = 1'b0;
		end
	end
	always_ff @(posedge srcClk) begin
		if (srcRst) begin
			s <= '0;
		end else if (srcEn) begin
			s <= next_s;
		end
	end

	always_comb begin
		next_d = d;
		next_d.req1 = s.req;
		next_d.req2 = d.req1;
		next_d.fresh = 1'b0;
		if (d.req2 != d.ack) begin
			next_d.word = s.hold;
			next_d.ack = d.req2;
			next_d.fresh = 1'b1;
		end
	end
	always_ff @(posedge dstClk) begin
		if (dstRst) begin
			d <= '0;
		end else if (dstEn) begin
			d <= next_d;
		end
	end

	assign port.srcBusy = s.busy;
	assign port.dstWord = d.word;
	assign port.dstNew  = d.fresh;
endmodule : srbt_handshake

// file: core/srbt_pkg.sv
// Shared constants and types for the read burst timing block
package srbt_pkg;
	// --------------------------------------------------------------
	// Register map and field layout
	// --------------------------------------------------------------
	localparam logic [7:0]  ADDR_MODE   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_ERROR  = 8'h08;
	localparam int          BURST_LSB   = 0;
	localparam int          CAS_LSB     = 8;
	localparam int          AL_LSB      = 16;
	localparam int          DLL_BIT     = 24;
	localparam int          LOCK_BIT    = 0;
	localparam int          BUSY_BIT    = 1;
	localparam int          OPEN_LSB    = 16;
	localparam logic [1:0]  BURST_RST   = 2'h0;
	localparam logic [4:0]  CAS_RST     = 5'h0B;
	localparam logic [4:0]  AL_RST      = 5'h00;
	localparam logic        DLL_RST     = 1'b0;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
	// --------------------------------------------------------------
	// Burst shape and queue sizing
	// --------------------------------------------------------------
	localparam logic [1:0]  LAST_PAIR_EIGHT = 2'h3;
	localparam logic [1:0]  LAST_PAIR_CHOP  = 2'h1;
	localparam logic [2:0]  QUEUE_DEPTH     = 3'h4;
	localparam int          BANKS           = 16;
	localparam int          CFG_W           = 13;

	typedef enum logic [1:0] {
		BURST_FIXED8 = 2'b00,
		BURST_OTF    = 2'b01,
		BURST_CHOP4  = 2'b10
	} srbt_burst_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE  = 2'b01,
		ST_DATA = 2'b10,
		ST_POST = 2'b11
	} srbt_state_type;

	typedef struct packed {
		logic       dllEn;
		logic [4:0] al;
		logic [4:0] cas;
		logic [1:0] burst;
	} srbt_cfg_type;

	typedef struct packed {
		logic [3:0] bank;
		logic [7:0] col;
		logic       chop;
		logic       ap;
		logic [6:0] due;
	} srbt_entry_type;
endpackage : srbt_pkg

// file: core/srbt_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module srbt_sync #(parameter int WIDTH = 1) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} srbt_sync_type;
	srbt_sync_type r;
	srbt_sync_type next_r;

	// No reset: this also carries the reset itself into the link domain
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end
	always_ff @(posedge clk) begin
		r <= next_r;
	end
	assign q = r.s2;
endmodule : srbt_sync

// file: core/srbt_word_if.sv
// Word carrier between the core and a clock crossing
`timescale 1ns/1ps
interface srbt_word_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] srcWord;
	logic             srcBusy;
	logic [WIDTH-1:0] dstWord;
	logic             dstNew;
	modport user (output srcWord, input srcBusy, input dstWord, input dstNew);
	modport xfer (input srcWord, output srcBusy, output dstWord, output dstNew);
endinterface : srbt_word_if

// file: test/sdram_read_burst_timing_tb.sv
// Self-checking bench for the read burst engine
`timescale 1ns/1ps
module sdram_read_burst_timing_tb;
	import srbt_pkg::*;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic        clk = 1'b0;
	logic        linkClk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clkEn = 1'b1;
	logic        dllLockPin = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, cmdRead, cmdActivate, dqOe, dqsT, dqsC, dqsOe;
	logic [13:0] cmdAddr;
	logic [3:0]  cmdBank;
	logic [7:0]  dqRise, dqFall;
	logic [31:0] q;
	logic        e;
	int          lat;
	int          n_fail = 0;
	int          check_count = 0;

	always #5 clk = ~clk;
	// Link edges fall on even nanoseconds, never on a system clock rise
	always #32 linkClk = ~linkClk;

	srbt_core srbt_core_i (.clk(clk), .clkEn(clkEn), .sys_rst(sys_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .linkClk(linkClk), .cmdRead(cmdRead),
		.cmdActivate(cmdActivate), .cmdAddr(cmdAddr), .cmdBank(cmdBank),
		.dllLockPin(dllLockPin), .dqRise(dqRise), .dqFall(dqFall), .dqOe(dqOe), .dqsT(dqsT),
		.dqsC(dqsC), .dqsOe(dqsOe));
	srbt_ctrl_model srbt_ctrl_model_i (.linkClk(linkClk), .dqRise(dqRise), .dqFall(dqFall),
		.dqOe(dqOe), .cmdRead(cmdRead), .cmdActivate(cmdActivate), .cmdAddr(cmdAddr),
		.cmdBank(cmdBank));

	// --------------------------------------------------
	// Bus and compare helpers
	// --------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", ONE, {31'h0, pready});
	endtask : apb
	// Waits long enough for the mode word to reach the link domain
	task automatic mode_set(input logic [1:0] m, input logic [4:0] addLat, casLat);
		apb(1'b1, ADDR_MODE, {7'h00, 1'b1, 3'h0, addLat, 3'h0, casLat, 6'h00, m});
		repeat (12) @(posedge linkClk);
	endtask : mode_set

	// --------------------------------------------------
	// Scenarios
	// --------------------------------------------------
	task automatic t_regs;
		apb(1'b0, ADDR_MODE, 32'h0000_0000);
		chk("mode reset", {7'h00, DLL_RST, 3'h0, AL_RST, 3'h0, CAS_RST, 6'h00, BURST_RST}, q);
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		chk("unmapped err", ONE, {31'h0, e});
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("unmapped data", 32'h0000_0000, q);
	endtask : t_regs
	task automatic t_refuse;
		srbt_ctrl_model_i.act(4'h5);
		srbt_ctrl_model_i.rd(4'h5, 1'b1, 1'b0, 8'h10, lat);
		chk("dll off", 0, lat);
		mode_set(2'b00, 5'h00, 5'h0B);
		srbt_ctrl_model_i.rd(4'h5, 1'b1, 1'b0, 8'h10, lat);
		chk("unlocked", 0, lat);
		@(posedge linkClk);
		dllLockPin <= 1'b1;
		repeat (4) @(posedge linkClk);
		srbt_ctrl_model_i.rd(4'h6, 1'b1, 1'b0, 8'h10, lat);
		chk("closed bank", 0, lat);
		apb(1'b0, ADDR_ERROR, 32'h0000_0000);
		chk("error flags", 32'h0000_0003, q);
		apb(1'b1, ADDR_ERROR, 32'h0000_0003);
		apb(1'b0, ADDR_ERROR, 32'h0000_0000);
		chk("error clear", 32'h0000_0000, q);
	endtask : t_refuse
	task automatic t_burst(input logic [1:0] m, input logic a12, a10,
		input logic [4:0] addLat, casLat, input logic [3:0] b, input logic [7:0] c, input int nb);
		int expLat;
		expLat = addLat + casLat;
		mode_set(m, addLat, casLat);
		srbt_ctrl_model_i.act(b);
		srbt_ctrl_model_i.rd(b, a12, a10, c, lat);
		chk("latency", expLat, lat);
		chk("beat count", nb, srbt_ctrl_model_i.beats.size());
		for (int i = 0; i < srbt_ctrl_model_i.beats.size(); i++)
			chk("beat", {24'h0, 8'(c + i)}, {24'h0, srbt_ctrl_model_i.beats[i]});
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk("bank open", {31'h0, !a10}, {31'h0, q[OPEN_LSB + b]});
	endtask : t_burst
	// Two reads spaced one burst apart stream on; one more cycle leaves a shared amble
	task automatic t_stream(input int sp, input logic [3:0] b);
		mode_set(2'b00, 5'h00, 5'h0B);
		srbt_ctrl_model_i.act(b);
		srbt_ctrl_model_i.rd2(b, 8'h60, sp, lat);
		chk("stream latency", 32'h0000_000B, lat);
		chk("stream beats", 16, srbt_ctrl_model_i.beats.size());
		for (int i = 0; i < srbt_ctrl_model_i.beats.size(); i++)
			chk("stream beat", {24'h0, 8'(8'h60 + i)}, {24'h0, srbt_ctrl_model_i.beats[i]});
	endtask : t_stream

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	initial begin
		repeat (5) @(posedge linkClk);
		@(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_refuse();
		t_burst(2'b00, 1'b0, 1'b0, 5'h00, 5'h0B, 4'h1, 8'hFE, 8);
		t_burst(2'b10, 1'b1, 1'b1, 5'h00, 5'h0B, 4'h2, 8'h20, 4);
		t_burst(2'b01, 1'b1, 1'b0, 5'h00, 5'h0B, 4'h9, 8'h30, 8);
		t_burst(2'b01, 1'b0, 1'b1, 5'h0A, 5'h0B, 4'hC, 8'h40, 4);
		t_burst(2'b11, 1'b0, 1'b0, 5'h00, 5'h0B, 4'h3, 8'h50, 8);
		t_stream(4, 4'h7);
		t_stream(5, 4'hB);
		results();
	end
	// Whole sequence needs about 35 us; a hang is cut off well beyond that
	initial begin
		#300000;
		n_fail++;
		results();
	end
endmodule : sdram_read_burst_timing_tb

// file: test/srbt_core_chk.sv
// Port-level assertions for the read burst engine
`timescale 1ns/1ps
module srbt_core_chk (
	input wire logic       clk,
	input wire logic       clkEn,
	input wire logic       sys_rst,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       linkClk,
	input wire logic [7:0] dqRise,
	input wire logic [7:0] dqFall,
	input wire logic       dqOe,
	input wire logic       dqsT,
	input wire logic       dqsC,
	input wire logic       dqsOe
);
	sequence s_amble;
		!dqOe && dqsOe && !dqsT && dqsC;
	endsequence
	property p_pre;
		@(posedge linkClk) disable iff (sys_rst) !dqsOe ##1 dqsOe |-> s_amble ##1 dqOe [*2];
	endproperty
	a_pre: assert property (p_pre) else $error("strobe start lacks preamble");
	property p_post;
		@(posedge linkClk) disable iff (sys_rst) dqOe ##1 !dqOe |-> s_amble;
	endproperty
	a_post: assert property (p_post) else $error("data end lacks postamble");
	property p_rel;
		@(posedge linkClk) disable iff (sys_rst) $fell(dqsOe) |-> !$past(dqOe);
	endproperty
	a_rel: assert property (p_rel) else $error("strobe released straight after data");
	property p_tog;
		@(posedge linkClk) disable iff (sys_rst) dqOe |-> dqsOe && dqsT && !dqsC;
	endproperty
	a_tog: assert property (p_tog) else $error("data cycle without toggling strobe");
	property p_pair;
		@(posedge linkClk) disable iff (sys_rst) dqOe |-> dqFall == dqRise + 8'h01;
	endproperty
	a_pair: assert property (p_pair) else $error("falling beat not next column");
	property p_rst;
		@(posedge linkClk) sys_rst [*4] |-> !dqOe && !dqsOe;
	endproperty
	a_rst: assert property (p_rst) else $error("link outputs driven in reset");
	property p_ans;
		@(posedge clk) disable iff (sys_rst) psel && penable && !pready && clkEn |=> pready;
	endproperty
	a_ans: assert property (p_ans) else $error("bus access not answered");
	property p_one;
		@(posedge clk) disable iff (sys_rst) pready && clkEn |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("ready held over one cycle");
endmodule : srbt_core_chk

bind srbt_core srbt_core_chk srbt_core_chk_i (.clk(clk), .clkEn(clkEn), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pready(pready), .linkClk(linkClk), .dqRise(dqRise),
	.dqFall(dqFall), .dqOe(dqOe), .dqsT(dqsT), .dqsC(dqsC), .dqsOe(dqsOe));

// file: test/srbt_ctrl_model.sv
// Memory controller model: issues link commands and captures read beats
`timescale 1ns/1ps
module srbt_ctrl_model (
	input  wire logic        linkClk,
	input  wire logic [7:0]  dqRise,
	input  wire logic [7:0]  dqFall,
	input  wire logic        dqOe,
	output logic             cmdRead,
	output logic             cmdActivate,
	output logic      [13:0] cmdAddr,
	output logic      [3:0]  cmdBank
);
	logic [7:0] beats[$];
	initial begin
		cmdRead = 1'b0;
		cmdActivate = 1'b0;
		cmdAddr = 14'h0000;
		cmdBank = 4'h0;
	end
	// Idle command lines show the inverse of the last value, never a stale copy
	task automatic act(input logic [3:0] b);
		@(posedge linkClk);
		cmdActivate <= 1'b1;
		cmdBank <= b;
		@(posedge linkClk);
		cmdActivate <= 1'b0;
		cmdBank <= ~b;
	endtask : act
	// Only reads and activates are issued, so no read-write spacing arises
	task automatic rd(input logic [3:0] b, input logic a12, a10,
		input logic [7:0] c, output int lat);
		@(posedge linkClk);
		cmdRead <= 1'b1;
		cmdBank <= b;
		cmdAddr <= {1'b0, a12, 1'b0, a10, 2'b00, c};
		@(posedge linkClk);
		cmdRead <= 1'b0;
		cmdBank <= ~b;
		cmdAddr <= ~cmdAddr;
		lat = 0;
		beats.delete();
		for (int n = 1; n < 40; n++) begin
			@(negedge linkClk);
			if (dqOe === 1'b1) begin
				if (lat == 0)
					// Sample n lies inside cycle n-1 counted from the command edge
					lat = n - 1;
				beats.push_back(dqRise);
				beats.push_back(dqFall);
			end
		end
	endtask : rd
	// Two reads to one open bank, the second sp cycles after the first and
	// eight columns further on, so all sixteen beats count up from c
	task automatic rd2(input logic [3:0] b, input logic [7:0] c, input int sp, output int lat);
		fork
			rd(b, 1'b1, 1'b0, c, lat);
			begin
				repeat (sp + 1) @(posedge linkClk);
				cmdRead <= 1'b1;
				cmdBank <= b;
				cmdAddr <= {1'b0, 1'b1, 1'b0, 1'b0, 2'b00, c + 8'h08};
				@(posedge linkClk);
				cmdRead <= 1'b0;
				cmdBank <= ~b;
				cmdAddr <= ~cmdAddr;
			end
		join
	endtask : rd2
endmodule : srbt_ctrl_model
